// [common/lcirq_pkg.sv]
// constants and types for the logic cell interrupt and mirror control block
package lcirq_pkg;
  localparam int N_CELLS = 4;
  localparam int N_GATES = 4;
  localparam int REG_W = 8;
  // cell_control fields
  localparam int CTL_EN_BIT = 7;
  localparam int CTL_OUT_BIT = 5;
  localparam int CTL_RISE_BIT = 4;
  localparam int CTL_FALL_BIT = 3;
  localparam int CTL_MODE_LSB = 0;
  localparam int CTL_MODE_W = 3;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] CTL_WR_MASK = 8'h9F;
  // cell_polarity fields
  localparam int POL_OUT_BIT = 7;
  localparam int POL_GATE_LSB = 0;
  typedef enum logic [2:0] {
    LCIRQ_AND_OR,
    LCIRQ_OR_XOR,
    LCIRQ_AND4,
    LCIRQ_SR_LATCH,
    LCIRQ_DFF_SR,
    LCIRQ_DFF_R,
    LCIRQ_JK_R,
    LCIRQ_DLATCH
  } lcirq_mode_e;
endpackage

// [src/lcirq_ctrl.sv]
// logic cells with edge interrupt flags, output mirror and control registers
// Behaviour
// RULE_01 - each cell has a rising and a falling output detector, used for interrupts only
// RULE_02 - flag sets when either detector fires with its own enable set
// RULE_03 - rise enable gates rising detector, fall enable gates falling; both in control
// RULE_04 - software sets cell, edge, peripheral and global enables to get interrupts
// RULE_05 - flag stays set until software clears it during service
// RULE_06 - an edge in the same cycle as a clear leaves the flag set
// RULE_07 - read-only mirror holds every cell output, one bit per cell
// RULE_08 - mirror presents all cell outputs captured at one instant
// RULE_09 - any reset clears the whole control register to zero
// RULE_10 - reset leaves polarity, gate and input selections unchanged
// RULE_11 - cell logic and edge detection keep running in sleep
// RULE_12 - enabled cell using fast oscillator keeps that oscillator running in sleep
// RULE_13 - software disables the cell before changing input, gate or polarity
// RULE_14 - software routes inputs via four gate sources and sets gate inversion
// RULE_15 - 3-bit field selects the logic function; separate bit inverts output
// RULE_16 - software sets the cell enable bit as the last setup step
// RULE_17 - interrupt request only when flag, cell, peripheral and global enables set
`timescale 1ns/1ns
module lcirq_ctrl (
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // control register writes, one strobe per cell
  input wire logic [lcirq_pkg::N_CELLS-1:0] ctl_wr_i,
  input wire logic [lcirq_pkg::REG_W-1:0] ctl_wdata_i,
  // polarity register writes, kept through reset
  input wire logic [lcirq_pkg::N_CELLS-1:0] pol_wr_i,
  input wire logic [lcirq_pkg::REG_W-1:0] pol_wdata_i,
  // gate inputs after source selection, asynchronous
  input wire logic [lcirq_pkg::N_CELLS-1:0][lcirq_pkg::N_GATES-1:0] gate_i,
  input wire logic [lcirq_pkg::N_CELLS-1:0] fast_osc_sel_i,
  // interrupt enables and flag clears
  input wire logic [lcirq_pkg::N_CELLS-1:0] cell_irq_enable_i,
  input wire logic peripheral_irq_enable_i,
  input wire logic global_irq_enable_i,
  input wire logic [lcirq_pkg::N_CELLS-1:0] flag_clr_i,
  // status
  output logic [lcirq_pkg::N_CELLS-1:0][lcirq_pkg::REG_W-1:0] cell_control_o,
  output logic [lcirq_pkg::N_CELLS-1:0][lcirq_pkg::REG_W-1:0] cell_polarity_o,
  output logic [lcirq_pkg::N_CELLS-1:0] cell_output_mirror_o,
  output logic [lcirq_pkg::N_CELLS-1:0] cell_irq_flag_o,
  output logic fast_osc_keep_o,
  output logic irq_o
);

  logic [lcirq_pkg::N_CELLS-1:0][lcirq_pkg::N_GATES-1:0] gate_s1_r;
  logic [lcirq_pkg::N_CELLS-1:0][lcirq_pkg::N_GATES-1:0] gate_s2_r;
  logic [lcirq_pkg::N_CELLS-1:0][lcirq_pkg::REG_W-1:0] ctl_r;
  logic [lcirq_pkg::N_CELLS-1:0][lcirq_pkg::REG_W-1:0] pol_r;
  logic [lcirq_pkg::N_CELLS-1:0] out_r;
  logic [lcirq_pkg::N_CELLS-1:0] prev_r;
  logic [lcirq_pkg::N_CELLS-1:0] flag_r;
  wire [lcirq_pkg::N_CELLS-1:0] flag_nxt;
  wire [lcirq_pkg::N_CELLS-1:0] out_nxt;
  wire [lcirq_pkg::N_CELLS-1:0] rise_evt;
  wire [lcirq_pkg::N_CELLS-1:0] fall_evt;
  wire [lcirq_pkg::N_CELLS-1:0] cell_en;
  logic osc_keep_r;
  wire irq_nxt;

  // gate inputs cross into the clock domain first
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      gate_s1_r <= '0;
      gate_s2_r <= '0;
    end else begin
      gate_s1_r <= gate_i;
      gate_s2_r <= gate_s1_r;
    end
  end

  for (genvar i = 0; i < lcirq_pkg::N_CELLS; i++) begin : g_cell
    wire [lcirq_pkg::N_GATES-1:0] g;
    wire [2:0] mode;
    wire rise_en;
    wire fall_en;
    wire g1_rise;
    logic st_r;
    logic g1_prev_r;
    logic st_nxt;
    logic core;

    assign g = gate_s2_r[i] ^ pol_r[i][lcirq_pkg::POL_GATE_LSB +: lcirq_pkg::N_GATES];
    assign mode = ctl_r[i][lcirq_pkg::CTL_MODE_LSB +: lcirq_pkg::CTL_MODE_W];
    assign rise_en = ctl_r[i][lcirq_pkg::CTL_RISE_BIT];
    assign fall_en = ctl_r[i][lcirq_pkg::CTL_FALL_BIT];
    assign cell_en[i] = ctl_r[i][lcirq_pkg::CTL_EN_BIT];
    assign g1_rise = g[0] & ~g1_prev_r;

    // function select and storage element of the cell
    always_comb begin // [RULE_15]
      st_nxt = st_r;
      core = st_r;
      case (mode)
        lcirq_pkg::LCIRQ_AND_OR: core = (g[0] & g[1]) | (g[2] & g[3]);
        lcirq_pkg::LCIRQ_OR_XOR: core = (g[0] | g[1]) ^ (g[2] | g[3]);
        lcirq_pkg::LCIRQ_AND4: core = &g;
        lcirq_pkg::LCIRQ_SR_LATCH: begin
          if (g[2] | g[3]) begin
            st_nxt = 1'b0;
          end else if (g[0] | g[1]) begin
            st_nxt = 1'b1;
          end
        end
        lcirq_pkg::LCIRQ_DFF_SR: begin
          if (g[2]) begin
            st_nxt = 1'b0;
          end else if (g[3]) begin
            st_nxt = 1'b1;
          end else if (g1_rise) begin
            st_nxt = g[1];
          end
        end
        lcirq_pkg::LCIRQ_DFF_R: begin
          if (g[2]) begin
            st_nxt = 1'b0;
          end else if (g1_rise) begin
            st_nxt = g[1] | g[3];
          end
        end
        lcirq_pkg::LCIRQ_JK_R: begin
          if (g[2]) begin
            st_nxt = 1'b0;
          end else if (g1_rise) begin
            st_nxt = (g[1] & ~st_r) | (~g[3] & st_r);
          end
        end
        lcirq_pkg::LCIRQ_DLATCH: begin
          if (g[0]) begin
            st_nxt = g[1];
          end
        end
        default: core = 1'b0;
      endcase
    end

    // final inversion; a disabled cell drives low
    assign out_nxt[i] = cell_en[i] & (core ^ pol_r[i][lcirq_pkg::POL_OUT_BIT]); // [RULE_15]
    assign rise_evt[i] = out_r[i] & ~prev_r[i]; // [RULE_01]
    assign fall_evt[i] = ~out_r[i] & prev_r[i]; // [RULE_01]
    // set wins over the clear
    assign flag_nxt[i] = (flag_r[i] & ~flag_clr_i[i]) // [RULE_05] [RULE_06]
                       | (rise_evt[i] & rise_en) | (fall_evt[i] & fall_en); // [RULE_02] [RULE_03]

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        st_r <= 1'b0;
        g1_prev_r <= 1'b0;
      end else begin
        st_r <= cell_en[i] ? st_nxt : 1'b0;
        g1_prev_r <= g[0];
      end
    end

    // control register cleared by reset, output bit read-only
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        ctl_r[i] <= lcirq_pkg::CTL_RESET; // [RULE_09]
      end else if (ctl_wr_i[i]) begin
        ctl_r[i] <= ctl_wdata_i & lcirq_pkg::CTL_WR_MASK;
      end
    end

    // polarity holds its value across reset
    always_ff @(posedge mclk_i) begin
      if (pol_wr_i[i]) begin
        pol_r[i] <= pol_wdata_i; // [RULE_10]
      end
    end

    always_comb begin
      cell_control_o[i] = ctl_r[i];
      cell_control_o[i][lcirq_pkg::CTL_OUT_BIT] = out_r[i];
    end
    rise_sets_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE_02]
      (rise_evt[i] && rise_en) |=> flag_r[i])
      else $error("rising edge did not set flag");
    fall_gate_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE_03]
      (!flag_r[i] && fall_evt[i] && !fall_en && !(rise_evt[i] && rise_en)) |=> !flag_r[i])
      else $error("disabled falling edge set flag");
    flag_hold_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE_05]
      (flag_r[i] && !flag_clr_i[i]) |=> flag_r[i])
      else $error("flag dropped without clear");
    clear_race_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE_06]
      (flag_clr_i[i] && ((rise_evt[i] && rise_en) || (fall_evt[i] && fall_en)))
      |=> flag_r[i])
      else $error("edge lost against clear");
    off_cell_low_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE_15]
      (!cell_en[i] && !ctl_wr_i[i]) |=> !out_r[i])
      else $error("disabled cell output not low");
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      out_r <= '0;
      prev_r <= '0;
      flag_r <= '0;
      osc_keep_r <= 1'b0;
      cell_output_mirror_o <= '0;
      irq_o <= 1'b0;
    end else begin
      out_r <= out_nxt; // [RULE_11]
      prev_r <= out_r;
      flag_r <= flag_nxt;
      osc_keep_r <= |(cell_en & fast_osc_sel_i); // [RULE_12]
      cell_output_mirror_o <= out_nxt; // [RULE_07] [RULE_08]
      irq_o <= irq_nxt;
    end
  end

  assign irq_nxt = (|(flag_nxt & cell_irq_enable_i))
                 & peripheral_irq_enable_i & global_irq_enable_i; // [RULE_17]
  assign cell_irq_flag_o = flag_r;
  assign cell_polarity_o = pol_r;
  assign fast_osc_keep_o = osc_keep_r;

  mirror_match_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE_08]
    cell_output_mirror_o == out_r)
    else $error("mirror differs from cell outputs");
  irq_cause_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE_17]
    irq_o == ((|(flag_r & $past(cell_irq_enable_i))) && $past(peripheral_irq_enable_i)
              && $past(global_irq_enable_i)))
    else $error("interrupt request without cause");
  reset_clear_a: assert property (@(posedge mclk_i) // [RULE_09]
    $fell(sys_rst_i) |-> (ctl_r == '0) && !fast_osc_keep_o)
    else $error("control not cleared by reset");
  osc_keep_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE_12]
    (|(cell_en & fast_osc_sel_i)) |=> fast_osc_keep_o)
    else $error("fast oscillator not held");
  edge_seen_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RULE_01] [RULE_11]
    (out_nxt != out_r) |=> (rise_evt | fall_evt) == $past(out_nxt ^ out_r))
    else $error("output change not detected");

endmodule

// [tb/lcirq_ctrl_test.sv]
// self-checking bench for the logic cell interrupt and mirror block
`timescale 1ns/1ns
module lcirq_ctrl_test;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [3:0] ctl_wr_i = 4'h0, pol_wr_i = 4'h0, fast_osc_sel_i = 4'h0;
  logic [3:0] cell_irq_enable_i = 4'h1, flag_clr_i = 4'h0;
  logic [7:0] ctl_wdata_i = 8'h00, pol_wdata_i = 8'h00;
  logic [3:0][3:0] gate_i = '0;
  logic peripheral_irq_enable_i = 1'b1, global_irq_enable_i = 1'b1;
  logic [3:0][7:0] ctl_o, pol_o;
  logic [3:0] mir_o, flg_o;
  logic keep_o, irq_o;
  // expected output per function for gate patterns 1,2 then 3,4 then 1,4
  logic [7:0] exp_a = 8'hFB, exp_b = 8'h83, exp_c = 8'h30;
  int fails = 0;
  int checks = 0;
  always #2 mclk_i = ~mclk_i;
  lcirq_ctrl dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ctl_wr_i(ctl_wr_i),
    .ctl_wdata_i(ctl_wdata_i), .pol_wr_i(pol_wr_i), .pol_wdata_i(pol_wdata_i),
    .gate_i(gate_i), .fast_osc_sel_i(fast_osc_sel_i), .cell_irq_enable_i(cell_irq_enable_i),
    .peripheral_irq_enable_i(peripheral_irq_enable_i),
    .global_irq_enable_i(global_irq_enable_i), .flag_clr_i(flag_clr_i),
    .cell_control_o(ctl_o), .cell_polarity_o(pol_o), .cell_output_mirror_o(mir_o),
    .cell_irq_flag_o(flg_o), .fast_osc_keep_o(keep_o), .irq_o(irq_o));
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic wr_ctl(input int c, input logic [7:0] d);
    @(posedge mclk_i);
    ctl_wdata_i <= d;
    ctl_wr_i[c] <= 1'b1;
    @(posedge mclk_i);
    ctl_wr_i <= 4'h0;
  endtask
  task automatic wr_pol(input int c, input logic [7:0] d);
    @(posedge mclk_i);
    pol_wdata_i <= d;
    pol_wr_i[c] <= 1'b1;
    @(posedge mclk_i);
    pol_wr_i <= 4'h0;
  endtask
  // gate drive at an edge, then settle n cycles and sample at negedge
  task automatic gate(input int c, input logic [3:0] g, input int n);
    @(posedge mclk_i);
    gate_i[c] <= g;
    repeat (n) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask
  task automatic clr_flag();
    @(posedge mclk_i);
    flag_clr_i <= 4'h1;
    @(posedge mclk_i);
    flag_clr_i <= 4'h0;
    @(negedge mclk_i);
  endtask
  task automatic complete_run();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #4000;
    fails++;
    complete_run();
  end
  initial begin
    repeat (5) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(negedge mclk_i);
    for (int c = 0; c < 4; c++) chk8(ctl_o[c], 8'h00);
    wr_pol(0, 8'h00);
    wr_pol(1, 8'h00);
    wr_pol(2, 8'h80);
    wr_pol(3, 8'h00);
    wr_ctl(0, 8'hF8);
    wr_ctl(1, 8'h98);
    wr_ctl(2, 8'h80);
    repeat (4) @(posedge mclk_i);
    @(negedge mclk_i);
    chk8(ctl_o[0], 8'h98);
    chkb(mir_o[2], 1'b1);
    // every function from a cleared state, three gate patterns each
    for (int m = 0; m < 8; m++) begin
      wr_ctl(3, 8'h00);
      wr_ctl(3, {5'b10000, m[2:0]});
      gate(3, 4'h3, 5);
      chkb(mir_o[3], exp_a[m]);
      gate(3, 4'hC, 5);
      chkb(mir_o[3], exp_b[m]);
      gate(3, 4'h9, 5);
      chkb(mir_o[3], exp_c[m]);
      gate(3, 4'h0, 5);
    end
    @(posedge mclk_i);
    gate_i[0] <= 4'h3;
    gate_i[1] <= 4'h3;
    for (int k = 0; k < 6; k++) begin
      @(negedge mclk_i);
      chkb(mir_o[1], mir_o[0]);
    end
    chkb(flg_o[0], 1'b1);
    chk8(ctl_o[0], 8'hB8);
    chkb(mir_o[0], 1'b1);
    chkb(irq_o, 1'b1);
    @(posedge mclk_i);
    global_irq_enable_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    @(negedge mclk_i);
    chkb(irq_o, 1'b0);
    @(posedge mclk_i);
    global_irq_enable_i <= 1'b1;
    repeat (10) @(negedge mclk_i);
    chkb(irq_o, 1'b1);
    chkb(flg_o[0], 1'b1);
    clr_flag();
    chkb(flg_o[0], 1'b0);
    chkb(irq_o, 1'b0);
    wr_ctl(0, 8'h90);
    gate(0, 4'h0, 6);
    chkb(flg_o[0], 1'b0);
    wr_ctl(0, 8'h88);
    gate(0, 4'h3, 6);
    chkb(flg_o[0], 1'b0);
    gate(0, 4'h0, 6);
    chkb(flg_o[0], 1'b1);
    wr_ctl(0, 8'h98);
    // clear sampled on the same edge as the rising event
    @(posedge mclk_i);
    gate_i[0] <= 4'h3;
    flag_clr_i <= 4'h1;
    @(posedge mclk_i);
    flag_clr_i <= 4'h0;
    repeat (2) @(posedge mclk_i);
    flag_clr_i <= 4'h1;
    @(posedge mclk_i);
    flag_clr_i <= 4'h0;
    @(negedge mclk_i);
    chkb(flg_o[0], 1'b1);
    @(posedge mclk_i);
    fast_osc_sel_i <= 4'h1;
    repeat (3) @(negedge mclk_i);
    chkb(keep_o, 1'b1);
    @(posedge mclk_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(negedge mclk_i);
    for (int c = 0; c < 4; c++) chk8(ctl_o[c], 8'h00);
    chk8(pol_o[2], 8'h80);
    chkb(keep_o, 1'b0);
    chk8({4'h0, flg_o}, 8'h00);
    chk8({4'h0, mir_o}, 8'h00);
    chkb(irq_o, 1'b0);
    @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    wr_ctl(2, 8'h80);
    repeat (3) @(negedge mclk_i);
    chkb(mir_o[2], 1'b1);
    chk8(ctl_o[3], 8'h00);
    chkb(flg_o[2], 1'b0);
    complete_run();
  end
endmodule
